// ==== pkg/pmc_pkg.sv ====
package pmc_pkg;

    // apb byte offsets
    localparam logic [11:0] PORT_CONTROL_OFF = 12'h000;
    localparam logic [11:0] PAD_CONFIG_OFF = 12'h004;
    localparam logic [11:0] PORT_STATUS_OFF = 12'h008;

    // port_control field positions
    localparam int PORT_ENABLE_BIT = 15;
    localparam int STOP_IN_IDLE_BIT = 13;
    localparam int ADDR_MUX_SEL_HI_BIT = 12;
    localparam int ADDR_MUX_SEL_LO_BIT = 11;
    localparam int BYTE_ENABLE_PORT_EN_BIT = 10;
    localparam int WRITE_STROBE_PORT_EN_BIT = 9;
    localparam int READ_STROBE_PORT_EN_BIT = 8;
    localparam int CS_FUNCTION_HI_BIT = 7;
    localparam int CS_FUNCTION_LO_BIT = 6;
    localparam int ADDR_LATCH_POLARITY_BIT = 5;
    localparam int CS1_POLARITY_BIT = 3;
    localparam int BYTE_ENABLE_POLARITY_BIT = 2;
    localparam int WRITE_STROBE_POLARITY_BIT = 1;
    localparam int READ_STROBE_POLARITY_BIT = 0;

    // pad_config field positions
    localparam int CLOCK_SECONDS_OUT_SEL_BIT = 1;
    localparam int PORT_INPUT_BUFFER_SEL_BIT = 0;

    // port_status field positions
    localparam int STATUS_ACTIVE_BIT = 0;
    localparam int STATUS_IDLE_BIT = 1;
    localparam int STATUS_HALTED_BIT = 2;

    localparam logic [15:0] PORT_CONTROL_RST = 16'h0000;
    localparam logic [15:0] PAD_CONFIG_RST = 16'h0000;
    // bits 14 and 4 do not exist
    localparam logic [15:0] PORT_CONTROL_WMASK = 16'hbfef;
    localparam logic [15:0] PAD_CONFIG_WMASK = 16'h0003;

    typedef enum logic [1:0] {
        PMC_MUX_SEPARATE = 2'b00,
        PMC_MUX_LOW8 = 2'b01,
        PMC_MUX_FULL = 2'b10,
        PMC_MUX_RSVD = 2'b11
    } pmc_mux_e;

    typedef enum logic [1:0] {
        PMC_PH_IDLE = 2'b00,
        PMC_PH_ADDR_LO = 2'b01,
        PMC_PH_ADDR_HI = 2'b10,
        PMC_PH_DATA = 2'b11
    } pmc_phase_e;

    // strobe pin indices
    localparam int STB_WR = 0;
    localparam int STB_RD = 1;
    localparam int STB_BE = 2;
    localparam int STB_CS1 = 3;
    localparam int STB_ALL = 4;
    localparam int STB_ALH = 5;
    localparam int NUM_STB = 6;

endpackage

// ==== logic/pmc_strobe_pin.sv ====
`timescale 1ns/1ps
module pmc_strobe_pin (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic active,
    input wire logic conn_en,
    input wire logic assert_req,
    input wire logic pol,
    input wire logic as_addr,
    input wire logic addr_bit,
    output logic pin_out,
    output logic pin_oe
);

    function automatic logic level_of(input logic on, input logic p);
        return on ? p : ~p;
    endfunction

    // an address line ignores polarity; a halted port parks strobes at the idle level and address lines at 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
        end else if (as_addr) begin
            pin_out <= active & addr_bit; // see R10
        end else begin
            pin_out <= level_of(active & assert_req, pol); // see R8 see R9 see R12
        end
    end

    // released pin returns to general i/o
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_oe <= 1'b0;
        end else begin
            pin_oe <= active & conn_en; // see R1 see R4 see R5 see R6
        end
    end

endmodule

// ==== logic/pmc_top.sv ====
// Notes on behaviour
// R1 - with port_enable clear the port is off and makes no external bus access.
// R2 - with stop_in_idle set the port halts while the device sits in idle mode.
// R3 - the mux field picks full multiplexing, low byte multiplexed with upper bits apart, or separate address pins.
// R4 - byte_enable_port_en connects the byte enable pin when 1 and releases it when 0.
// R5 - write_strobe_port_en connects the write strobe pin when set and releases it when clear.
// R6 - read_strobe_port_en connects the read strobe pin when set and releases it when clear.
// R7 - cs function 10 makes chip select 1 a chip select, 0x an address bit, and 11 is reserved.
// R8 - addr_latch_polarity makes the latch strobes active high when 1 and active low when 0.
// R9 - cs1_polarity makes chip select 1 active high when 1 and active low when 0.
// R10 - latch and chip select polarity do nothing while those pins carry address lines.
// R11 - bits 14 and 4 of port_control read zero and ignore writes.
// R12 - byte enable, write and read strobe each have a polarity bit of the same kind.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module pmc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cpu_idle,
    input wire logic [1:0] eng_phase,
    input wire logic [15:0] eng_addr,
    input wire logic [7:0] eng_wdata,
    input wire logic eng_rd,
    input wire logic eng_wr,
    input wire logic eng_be,
    input wire logic eng_cs1,
    output logic port_active,
    output logic [7:0] eng_rdata,
    output logic eng_rdata_valid,
    input wire logic [7:0] port_data_pins_in,
    output logic [7:0] port_data_pins_out,
    output logic port_data_pins_oe,
    output logic [13:2] addr_pins_out,
    output logic addr_pins_oe,
    output logic write_strobe_pin,
    output logic write_strobe_pin_oe,
    output logic read_strobe_pin,
    output logic read_strobe_pin_oe,
    output logic byte_enable_pin,
    output logic byte_enable_pin_oe,
    output logic chip_select1_pin,
    output logic chip_select1_pin_oe,
    output logic addr_latch_low_pin,
    output logic addr_latch_low_pin_oe,
    output logic addr_latch_high_pin,
    output logic addr_latch_high_pin_oe,
    output logic clock_seconds_out_sel,
    output logic port_input_buffer_sel
);

    logic [15:0] port_control_reg;
    logic [15:0] pad_config_reg;
    logic setup_cycle;
    logic access_done;
    logic sel_ctrl;
    logic sel_pad;
    logic sel_stat;
    logic mapped;
    logic run;
    logic halted;
    pmc_pkg::pmc_mux_e mux_mode;
    pmc_pkg::pmc_phase_e phase;
    logic [1:0] cs_func;
    logic [pmc_pkg::NUM_STB-1:0] stb_req;
    logic [pmc_pkg::NUM_STB-1:0] stb_conn;
    logic [pmc_pkg::NUM_STB-1:0] stb_pol;
    logic [pmc_pkg::NUM_STB-1:0] stb_as_addr;
    logic [pmc_pkg::NUM_STB-1:0] stb_addr_bit;
    logic [pmc_pkg::NUM_STB-1:0] stb_out;
    logic [pmc_pkg::NUM_STB-1:0] stb_oe;
    logic [7:0] data_next;
    logic data_oe_next;
    logic [13:2] addr_next;

    // reserved mux code behaves as full multiplexing
    function automatic pmc_pkg::pmc_mux_e mux_of(input logic [15:0] ctrl);
        logic [1:0] code;
        code = ctrl[pmc_pkg::ADDR_MUX_SEL_HI_BIT:pmc_pkg::ADDR_MUX_SEL_LO_BIT];
        return (code == pmc_pkg::PMC_MUX_RSVD) ? pmc_pkg::PMC_MUX_FULL : pmc_pkg::pmc_mux_e'(code);
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be,
                                            input logic [15:0] mask);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}} & mask;
        return (old & ~m) | (d[15:0] & m);
    endfunction

    // apb decode
    assign setup_cycle = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign sel_ctrl = (paddr == pmc_pkg::PORT_CONTROL_OFF);
    assign sel_pad = (paddr == pmc_pkg::PAD_CONFIG_OFF);
    assign sel_stat = (paddr == pmc_pkg::PORT_STATUS_OFF);
    assign mapped = sel_ctrl | sel_pad | sel_stat;

    // no wait state: ready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_cycle;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_cycle & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_cycle & ~pwrite) begin
            unique case (1'b1)
                sel_ctrl: prdata <= {16'h0000, port_control_reg};
                sel_pad: prdata <= {16'h0000, pad_config_reg};
                sel_stat: prdata <= {29'h0, halted, cpu_idle, run};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // write lands at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_control_reg <= pmc_pkg::PORT_CONTROL_RST;
        end else if (access_done & pwrite & sel_ctrl) begin
            port_control_reg <= merge16(port_control_reg, pwdata, pstrb, pmc_pkg::PORT_CONTROL_WMASK); // see R11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_config_reg <= pmc_pkg::PAD_CONFIG_RST;
        end else if (access_done & pwrite & sel_pad) begin
            pad_config_reg <= merge16(pad_config_reg, pwdata, pstrb, pmc_pkg::PAD_CONFIG_WMASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_seconds_out_sel <= 1'b0;
            port_input_buffer_sel <= 1'b0;
        end else begin
            clock_seconds_out_sel <= pad_config_reg[pmc_pkg::CLOCK_SECONDS_OUT_SEL_BIT];
            port_input_buffer_sel <= pad_config_reg[pmc_pkg::PORT_INPUT_BUFFER_SEL_BIT];
        end
    end

    // port run state
    assign halted = port_control_reg[pmc_pkg::STOP_IN_IDLE_BIT] & cpu_idle; // see R2
    assign run = port_control_reg[pmc_pkg::PORT_ENABLE_BIT] & ~halted; // see R1

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_active <= 1'b0;
        end else begin
            port_active <= run;
        end
    end

    assign mux_mode = mux_of(port_control_reg);
    assign phase = pmc_pkg::pmc_phase_e'(eng_phase);
    assign cs_func = port_control_reg[pmc_pkg::CS_FUNCTION_HI_BIT:pmc_pkg::CS_FUNCTION_LO_BIT];

    // data and address pin steering
    always_comb begin
        data_next = 8'h00;
        data_oe_next = 1'b0;
        addr_next = 12'h000;
        unique case (mux_mode)
            pmc_pkg::PMC_MUX_SEPARATE: begin
                addr_next = eng_addr[13:2]; // see R3
            end
            pmc_pkg::PMC_MUX_LOW8: begin
                addr_next = {eng_addr[13:11], eng_addr[10:8], 6'h00}; // see R3
                if (phase == pmc_pkg::PMC_PH_ADDR_LO) begin
                    data_next = eng_addr[7:0];
                    data_oe_next = 1'b1;
                end
            end
            default: begin
                if (phase == pmc_pkg::PMC_PH_ADDR_LO) begin
                    data_next = eng_addr[7:0]; // see R3
                    data_oe_next = 1'b1;
                end else if (phase == pmc_pkg::PMC_PH_ADDR_HI) begin
                    data_next = eng_addr[15:8];
                    data_oe_next = 1'b1;
                end
            end
        endcase
        if (phase == pmc_pkg::PMC_PH_DATA && eng_wr) begin
            data_next = eng_wdata;
            data_oe_next = 1'b1;
        end
    end

    // disabled port floats its bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_data_pins_out <= 8'h00;
            port_data_pins_oe <= 1'b0;
        end else begin
            port_data_pins_out <= run ? data_next : 8'h00;
            port_data_pins_oe <= run & data_oe_next; // see R1
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_pins_out <= 12'h000;
            addr_pins_oe <= 1'b0;
        end else begin
            addr_pins_out <= run ? addr_next : 12'h000;
            addr_pins_oe <= run & (mux_mode != pmc_pkg::PMC_MUX_FULL); // see R1 see R3
        end
    end

    // read data is sampled while the read strobe phase is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_rdata <= 8'h00;
            eng_rdata_valid <= 1'b0;
        end else begin
            eng_rdata_valid <= run & eng_rd & (phase == pmc_pkg::PMC_PH_DATA);
            if (run & eng_rd & (phase == pmc_pkg::PMC_PH_DATA)) begin
                eng_rdata <= port_data_pins_in;
            end
        end
    end

    // strobe pin setup
    always_comb begin
        stb_req = '0;
        stb_conn = '0;
        stb_pol = '0;
        stb_as_addr = '0;
        stb_addr_bit = '0;
        stb_req[pmc_pkg::STB_WR] = eng_wr & (phase == pmc_pkg::PMC_PH_DATA);
        stb_conn[pmc_pkg::STB_WR] = port_control_reg[pmc_pkg::WRITE_STROBE_PORT_EN_BIT]; // see R5
        stb_pol[pmc_pkg::STB_WR] = port_control_reg[pmc_pkg::WRITE_STROBE_POLARITY_BIT]; // see R12
        stb_req[pmc_pkg::STB_RD] = eng_rd & (phase == pmc_pkg::PMC_PH_DATA);
        stb_conn[pmc_pkg::STB_RD] = port_control_reg[pmc_pkg::READ_STROBE_PORT_EN_BIT]; // see R6
        stb_pol[pmc_pkg::STB_RD] = port_control_reg[pmc_pkg::READ_STROBE_POLARITY_BIT]; // see R12
        stb_req[pmc_pkg::STB_BE] = eng_be & (phase == pmc_pkg::PMC_PH_DATA);
        stb_conn[pmc_pkg::STB_BE] = port_control_reg[pmc_pkg::BYTE_ENABLE_PORT_EN_BIT]; // see R4
        stb_pol[pmc_pkg::STB_BE] = port_control_reg[pmc_pkg::BYTE_ENABLE_POLARITY_BIT]; // see R12
        // reserved chip select code leaves the pin released
        stb_req[pmc_pkg::STB_CS1] = eng_cs1 & (phase != pmc_pkg::PMC_PH_IDLE);
        stb_conn[pmc_pkg::STB_CS1] = (cs_func != 2'b11); // see R7
        stb_pol[pmc_pkg::STB_CS1] = port_control_reg[pmc_pkg::CS1_POLARITY_BIT]; // see R9
        stb_as_addr[pmc_pkg::STB_CS1] = ~cs_func[1]; // see R7
        stb_addr_bit[pmc_pkg::STB_CS1] = eng_addr[14];
        // latch pins double as address bits 0 and 1 when not latching
        stb_req[pmc_pkg::STB_ALL] = (phase == pmc_pkg::PMC_PH_ADDR_LO);
        stb_conn[pmc_pkg::STB_ALL] = 1'b1;
        stb_pol[pmc_pkg::STB_ALL] = port_control_reg[pmc_pkg::ADDR_LATCH_POLARITY_BIT]; // see R8
        stb_as_addr[pmc_pkg::STB_ALL] = (mux_mode == pmc_pkg::PMC_MUX_SEPARATE); // see R10
        stb_addr_bit[pmc_pkg::STB_ALL] = eng_addr[0];
        stb_req[pmc_pkg::STB_ALH] = (phase == pmc_pkg::PMC_PH_ADDR_HI);
        stb_conn[pmc_pkg::STB_ALH] = 1'b1;
        stb_pol[pmc_pkg::STB_ALH] = port_control_reg[pmc_pkg::ADDR_LATCH_POLARITY_BIT]; // see R8
        stb_as_addr[pmc_pkg::STB_ALH] = (mux_mode != pmc_pkg::PMC_MUX_FULL); // see R10
        stb_addr_bit[pmc_pkg::STB_ALH] = eng_addr[1];
    end

    genvar gi;
    generate
        for (gi = 0; gi < pmc_pkg::NUM_STB; gi++) begin : g_stb
            pmc_strobe_pin u_pin (
                .pclk(pclk),
                .presetn(presetn),
                .active(run),
                .conn_en(stb_conn[gi]),
                .assert_req(stb_req[gi]),
                .pol(stb_pol[gi]),
                .as_addr(stb_as_addr[gi]),
                .addr_bit(stb_addr_bit[gi]),
                .pin_out(stb_out[gi]),
                .pin_oe(stb_oe[gi])
            );
        end
    endgenerate

    assign write_strobe_pin = stb_out[pmc_pkg::STB_WR];
    assign write_strobe_pin_oe = stb_oe[pmc_pkg::STB_WR];
    assign read_strobe_pin = stb_out[pmc_pkg::STB_RD];
    assign read_strobe_pin_oe = stb_oe[pmc_pkg::STB_RD];
    assign byte_enable_pin = stb_out[pmc_pkg::STB_BE];
    assign byte_enable_pin_oe = stb_oe[pmc_pkg::STB_BE];
    assign chip_select1_pin = stb_out[pmc_pkg::STB_CS1];
    assign chip_select1_pin_oe = stb_oe[pmc_pkg::STB_CS1];
    assign addr_latch_low_pin = stb_out[pmc_pkg::STB_ALL];
    assign addr_latch_low_pin_oe = stb_oe[pmc_pkg::STB_ALL];
    assign addr_latch_high_pin = stb_out[pmc_pkg::STB_ALH];
    assign addr_latch_high_pin_oe = stb_oe[pmc_pkg::STB_ALH];

endmodule

// ==== sim/pmc_top_assertions.sv ====
`timescale 1ns/1ps
module pmc_top_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic port_active,
    input wire logic eng_rd,
    input wire logic [7:0] eng_rdata,
    input wire logic eng_rdata_valid,
    input wire logic [7:0] port_data_pins_in,
    input wire logic [7:0] port_data_pins_out,
    input wire logic port_data_pins_oe,
    input wire logic addr_pins_oe,
    input wire logic port_input_buffer_sel
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_unmapped_err: assert property (psel && !penable && !pwrite && !(paddr inside {12'h000, 12'h004, 12'h008})
        |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    chk_mapped_ok: assert property (psel && !penable && paddr == pmc_pkg::PORT_CONTROL_OFF |=> !pslverr)
        else $error("mapped access refused");
    chk_ctl_gaps_zero: assert property (psel && !penable && !pwrite && paddr == pmc_pkg::PORT_CONTROL_OFF
        |=> prdata[14] == 1'b0 && prdata[4] == 1'b0 && prdata[31:16] == 16'h0000)
        else $error("unimplemented control bits read set");
    chk_off_quiet: assert property (!port_active && !$past(port_active)
        |-> !port_data_pins_oe && !addr_pins_oe && port_data_pins_out == 8'h00)
        else $error("pins driven while port off");
    chk_rd_valid_cause: assert property (eng_rdata_valid |-> $past(eng_rd))
        else $error("read data valid without read");
    chk_rd_capture: assert property (eng_rdata_valid |-> eng_rdata == $past(port_data_pins_in))
        else $error("read data not captured from pins");
    chk_pad_copy: assert property (psel && penable && pready && pwrite && paddr == pmc_pkg::PAD_CONFIG_OFF && pstrb[0]
        |-> ##2 port_input_buffer_sel == $past(pwdata[0], 2))
        else $error("pad buffer select not copied");
endmodule

// ==== sim/pmc_periph_model.sv ====
`timescale 1ns/1ps
module pmc_periph_model #(
    parameter logic [7:0] RD_BYTE = 8'h5c
) (
    input wire logic pclk,
    input wire logic read_strobe_pin,
    input wire logic read_strobe_pin_oe,
    input wire logic rd_active_high,
    input wire logic port_data_pins_oe,
    output logic [7:0] port_data_pins_in
);
    logic [7:0] last_reg = 8'h00;
    wire rd_on = read_strobe_pin_oe && (read_strobe_pin == rd_active_high);
    // bus not ours: keep it moving so a stale value never looks valid
    assign port_data_pins_in = (rd_on && !port_data_pins_oe) ? RD_BYTE : ~last_reg;
    always @(posedge pclk) begin
        last_reg <= port_data_pins_in;
    end
endmodule

// ==== sim/pmc_top_tb.sv ====
`timescale 1ns/1ps
module pmc_top_tb;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] exp; logic err;} pmc_row_s;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, cpu_idle = 1'b0;
    logic eng_rd = 1'b0, eng_wr = 1'b0, eng_be = 1'b0, eng_cs1 = 1'b0, rd_pol = 1'b0, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [3:0] pstrb = 4'h0;
    logic [1:0] eng_phase = 2'b00;
    logic [15:0] eng_addr = 16'h0000;
    logic [7:0] eng_wdata = 8'h00, eng_rdata, port_data_pins_in, port_data_pins_out;
    logic [31:0] prdata;
    logic [13:2] addr_pins_out;
    logic pready, pslverr, port_active, eng_rdata_valid, port_data_pins_oe, addr_pins_oe;
    logic write_strobe_pin, write_strobe_pin_oe, read_strobe_pin, read_strobe_pin_oe, byte_enable_pin;
    logic byte_enable_pin_oe, chip_select1_pin, chip_select1_pin_oe, addr_latch_low_pin, addr_latch_low_pin_oe;
    logic addr_latch_high_pin, addr_latch_high_pin_oe, clock_seconds_out_sel, port_input_buffer_sel;
    int num_errors = 0, checked = 0;
    pmc_row_s rows[6] = '{
        '{12'h000, 32'hffff_ffff, 4'h0, 32'h0, 1'b0},
        '{12'h004, 32'hffff_ffff, 4'h0, 32'h0, 1'b0},
        '{12'h000, 32'hffff_ffff, 4'h1, 32'h0000_00ef, 1'b0},
        '{12'h000, 32'hffff_ffff, 4'h3, 32'h0000_bfef, 1'b0},
        '{12'h004, 32'hffff_ffff, 4'hf, 32'h0000_0003, 1'b0},
        '{12'h00c, 32'hffff_ffff, 4'hf, 32'h0, 1'b1}};

    pmc_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .cpu_idle, .eng_phase, .eng_addr, .eng_wdata, .eng_rd, .eng_wr, .eng_be, .eng_cs1, .port_active, .eng_rdata,
        .eng_rdata_valid, .port_data_pins_in, .port_data_pins_out, .port_data_pins_oe, .addr_pins_out, .addr_pins_oe,
        .write_strobe_pin, .write_strobe_pin_oe, .read_strobe_pin, .read_strobe_pin_oe, .byte_enable_pin,
        .byte_enable_pin_oe, .chip_select1_pin, .chip_select1_pin_oe, .addr_latch_low_pin, .addr_latch_low_pin_oe,
        .addr_latch_high_pin, .addr_latch_high_pin_oe, .clock_seconds_out_sel, .port_input_buffer_sel);
    pmc_periph_model PEER (.pclk, .read_strobe_pin, .read_strobe_pin_oe, .rd_active_high(rd_pol),
        .port_data_pins_oe, .port_data_pins_in);

    always #5 pclk = ~pclk;

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task print_verdict();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("mismatch pready expected 1 seen %b", pready);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task cfg(input logic [15:0] v);
        apb(1'b1, pmc_pkg::PORT_CONTROL_OFF, {16'h0000, v}, 4'h3);
        repeat (2) @(posedge pclk);
    endtask

    // inputs set after one edge, sampled at the next, then checked at the falling edge so the registered pins show the response
    task eng(input logic [1:0] ph, input logic [15:0] a, input logic r, input logic w);
        @(posedge pclk);
        eng_phase <= ph;
        eng_addr <= a;
        eng_rd <= r;
        eng_wr <= w;
        eng_wdata <= 8'ha5;
        eng_be <= w;
        eng_cs1 <= (ph != 2'b00);
        @(posedge pclk);
        @(negedge pclk);
    endtask

    initial begin
        #100us;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
            check("write err", 32'(er), 32'(rows[i].err));
            apb(1'b0, rows[i].a, 32'h0, 4'h0);
            check("read data", rd, rows[i].exp);
            check("read err", 32'(er), 32'(rows[i].err));
        end
        check("pad seconds sel", 32'(clock_seconds_out_sel), 32'h1);
        check("cs1 reserved oe", 32'(chip_select1_pin_oe), 32'h0);
        check("latch lo oe", 32'(addr_latch_low_pin_oe), 32'h1);
        check("mux rsvd addr oe", 32'(addr_pins_oe), 32'h0);
        $display("register table done");
        cfg(16'h13aa);
        eng(2'b01, 16'h1234, 1'b0, 1'b0);
        check("off data oe", 32'(port_data_pins_oe), 32'h0);
        check("off active", 32'(port_active), 32'h0);
        $display("port off done");
        cfg(16'h93aa);
        eng(2'b01, 16'h1234, 1'b0, 1'b0);
        check("addr lo", 32'(port_data_pins_out), 32'h34);
        check("latch lo", 32'(addr_latch_low_pin), 32'h1);
        check("cs1", 32'(chip_select1_pin), 32'h1);
        check("cs1 oe", 32'(chip_select1_pin_oe), 32'h1);
        eng(2'b10, 16'h1234, 1'b0, 1'b0);
        check("addr hi", 32'(port_data_pins_out), 32'h12);
        check("latch hi", 32'(addr_latch_high_pin), 32'h1);
        eng(2'b11, 16'h1234, 1'b0, 1'b1);
        check("wdata", 32'(port_data_pins_out), 32'ha5);
        check("wr strobe", 32'(write_strobe_pin), 32'h1);
        check("rd idle", 32'(read_strobe_pin), 32'h1);
        check("be level", 32'(byte_enable_pin), 32'h0);
        eng(2'b11, 16'h1234, 1'b1, 1'b0);
        eng(2'b11, 16'h1234, 1'b1, 1'b0);
        check("rd strobe", 32'(read_strobe_pin), 32'h0);
        check("rdata", 32'(eng_rdata), 32'h5c);
        check("rdata valid", 32'(eng_rdata_valid), 32'h1);
        $display("full mux done");
        for (int k = 0; k < 3; k++) begin
            cfg(16'h9000 | (16'h0100 << k));
            eng(2'b11, 16'h0000, 1'b0, 1'b1);
            check("rd oe", 32'(read_strobe_pin_oe), 32'(k == 0));
            check("wr oe", 32'(write_strobe_pin_oe), 32'(k == 1));
            check("be oe", 32'(byte_enable_pin_oe), 32'(k == 2));
        end
        $display("strobe enables done");
        cfg(16'h8300);
        eng(2'b01, 16'h4ff6, 1'b0, 1'b0);
        check("addr pins", 32'(addr_pins_out), 32'h3fd);
        check("cs1 as addr", 32'(chip_select1_pin), 32'h1);
        check("latch hi addr", 32'(addr_latch_high_pin), 32'h1);
        check("latch lo addr", 32'(addr_latch_low_pin), 32'h0);
        check("latch hi oe", 32'(addr_latch_high_pin_oe), 32'h1);
        $display("separate mode done");
        cfg(16'ha300);
        cpu_idle <= 1'b1;
        eng(2'b11, 16'h0000, 1'b0, 1'b1);
        check("idle halt", 32'(port_active), 32'h0);
        check("idle wr oe", 32'(write_strobe_pin_oe), 32'h0);
        cfg(16'h8300);
        check("idle run", 32'(port_active), 32'h1);
        cpu_idle <= 1'b0;
        $display("idle done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("reset rd pin", 32'(read_strobe_pin), 32'h0);
        presetn <= 1'b1;
        apb(1'b0, pmc_pkg::PORT_CONTROL_OFF, 32'h0, 4'h0);
        check("reset ctl", rd, 32'h0);
        check("parked rd pin", 32'(read_strobe_pin), 32'h1);
        check("reset pad sel", 32'(clock_seconds_out_sel), 32'h0);
        $display("second reset done");
        print_verdict();
    end
endmodule

bind pmc_top pmc_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .port_active, .eng_rd, .eng_rdata, .eng_rdata_valid, .port_data_pins_in, .port_data_pins_out,
    .port_data_pins_oe, .addr_pins_oe, .port_input_buffer_sel);
